// file: hw/spir_pkg.sv
// What this block does
// - eight banks of eight registers share offsets 00h-07h; only selected bank answers
// - banks 0-3 serve uart and ir; banks 4-7 serve ir only
// - bank selector at offset 03h in every bank, same as bank 0 form
// - two dma channels offered; ir uses one, full-duplex uart usually two
// - bank 1 holds legacy divisor low at 00h, high at 01h; rest reserved
// - bank 2 holds baud divisor low at 00h, high at 01h
// - bank 3 offset 00h reads module id bits 7-4, revision bits 3-0
// - bank 6 offset 02h holds sir pulse width, for rates up to 115 kbps
// - bank 7 offsets 00h-02h demod, mod, consumer-ir config, all read-only
// - bank 7 offsets 04h, 06h, 07h are read-write ir interface configs
// - selector bit7=0 bank 0; 10x bank 1; e0h..f4h banks 2-7
//
// Purpose: constants for the second serial port banked register file
// Assumes: 8-bit register port, 3-bit offset
// Notes:   bank 0 registers other than the selector live outside
package spir_pkg;
  localparam logic [2:0] OFF_0 = 3'h0;
  localparam logic [2:0] OFF_1 = 3'h1;
  localparam logic [2:0] OFF_2 = 3'h2;
  localparam logic [2:0] OFF_SEL = 3'h3;
  localparam logic [2:0] OFF_4 = 3'h4;
  localparam logic [2:0] OFF_6 = 3'h6;
  localparam logic [2:0] OFF_7 = 3'h7;
  localparam logic [7:0] SEL_B2 = 8'he0;
  localparam logic [7:0] SEL_B3 = 8'he4;
  localparam logic [7:0] SEL_B4 = 8'he8;
  localparam logic [7:0] SEL_B5 = 8'hec;
  localparam logic [7:0] SEL_B6 = 8'hf0;
  localparam logic [7:0] SEL_B7 = 8'hf4;
  localparam logic [7:0] RST_VAL = 8'h00;
  // writable bit masks per register; the consumer-ir config mask is applied on read
  localparam logic [7:0] MSK_EXT1 = 8'hb9;
  localparam logic [7:0] MSK_EXT2 = 8'hb0;
  localparam logic [7:0] MSK_FLV = 8'h1f;
  localparam logic [7:0] MSK_IRC1 = 8'h0c;
  localparam logic [7:0] MSK_IRC2 = 8'h13;
  localparam logic [7:0] MSK_IRC3 = 8'hc0;
  localparam logic [7:0] MSK_SPW = 8'h0f;
  localparam logic [7:0] MSK_CFG1 = 8'hff;
  localparam logic [7:0] MSK_CFG3 = 8'h77;
  localparam logic [7:0] MSK_CFG4 = 8'hb8;
  localparam logic [7:0] MSK_CONSUMER_IR_CONFIG = 8'hf7;
  localparam int MID_POS = 4;
  localparam int NUM_BANKS = 8;
endpackage

// file: hw/spir_bus_if.sv
`timescale 1ns/10ps
// Purpose: internal register access bundle
// Assumes: one clock
// Notes:   decoded strobes for the register modules
interface spir_bus_if;
  logic [2:0] bank;
  logic [2:0] off;
  logic [7:0] wdata;
  logic       wr;
  modport ctl (output bank, output off, output wdata, output wr);
  modport reg_side (input bank, input off, input wdata, input wr);
endinterface

// file: hw/spir_bank_dec.sv
`timescale 1ns/10ps
// Purpose: bank selector decode
// Assumes: selector value held by caller
// Notes:   unlisted 11xxxxxx codes fall to bank 1
module spir_bank_dec
  import spir_pkg::*;
(
  input  wire logic [7:0] i_sel,
  output logic      [2:0] o_bank
);
  assign o_bank = !i_sel[7]          ? 3'h0 :
                  !i_sel[6]          ? 3'h1 :
                  (i_sel == SEL_B2)  ? 3'h2 :
                  (i_sel == SEL_B3)  ? 3'h3 :
                  (i_sel == SEL_B4)  ? 3'h4 :
                  (i_sel == SEL_B5)  ? 3'h5 :
                  (i_sel == SEL_B6)  ? 3'h6 :
                  (i_sel == SEL_B7)  ? 3'h7 : 3'h1;
endmodule

// file: hw/spir_reg8.sv
`timescale 1ns/10ps
// Purpose: one masked 8-bit register at a bank/offset
// Assumes: synchronous reset
// Notes:   unmasked bits stay zero
module spir_reg8
  import spir_pkg::*;
#(
  parameter logic [2:0] BANK = 3'h0,
  parameter logic [2:0] OFF  = 3'h0,
  parameter logic [7:0] MASK = 8'hff
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  spir_bus_if.reg_side    bus,
  output logic      [7:0] o_q
);
  logic [7:0] q_r;
  wire        hit = bus.wr && (bus.bank == BANK) && (bus.off == OFF);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) q_r <= RST_VAL;
    else if (hit) q_r <= bus.wdata & MASK;
  end
  assign o_q = q_r;
endmodule

// file: hw/spir_regs.sv
`timescale 1ns/10ps
// Purpose: second serial port banked register file, banks 1-7 and selector
// Assumes: host port, read data one cycle after read strobe
// Notes:   bank 0 data registers answer elsewhere; read-only ones come from ports, except the id byte from parameters and the bank 3 selector shadow
module spir_regs
  import spir_pkg::*;
#(
  parameter logic [3:0] MODULE_ID   = 4'h1, // arbitrary value
  parameter logic [3:0] REVISION_ID = 4'h1  // arbitrary value
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_bank0_sel,
  input  wire logic [7:0] i_fifo_control_shadow,
  input  wire logic [7:0] i_ir_rx_demod_control,
  input  wire logic [7:0] i_ir_tx_mod_control,
  input  wire logic [7:0] i_consumer_ir_config,
  output logic      [7:0] o_line_control,
  output logic     [15:0] o_legacy_baud_divisor,
  output logic     [15:0] o_baud_divisor,
  output logic      [7:0] o_extended_control_1,
  output logic      [7:0] o_extended_control_2,
  output logic      [7:0] o_tx_fifo_level,
  output logic      [7:0] o_rx_fifo_level,
  output logic      [7:0] o_ir_control_1,
  output logic      [7:0] o_ir_control_2,
  output logic      [7:0] o_ir_control_3,
  output logic      [7:0] o_sir_pulse_width,
  output logic      [7:0] o_ir_interface_config_1,
  output logic      [7:0] o_ir_interface_config_3,
  output logic      [7:0] o_ir_interface_config_4,
  output logic      [2:0] o_active_bank,
  output logic            o_ir_only_bank
);
  spir_bus_if bus ();
  logic [7:0] bank_selector_r;
  logic [7:0] rdata_r;
  logic [7:0] rd_nxt;
  logic [2:0] bank;
  wire        sel_hit = i_wr && (i_addr == OFF_SEL);

  spir_bank_dec u_dec (
    .i_sel  (bank_selector_r),
    .o_bank (bank)
  );

  assign bus.bank  = bank;
  assign bus.off   = i_addr;
  assign bus.wdata = i_wdata;
  assign bus.wr    = i_wr && (i_addr != OFF_SEL);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bank_selector_r <= RST_VAL;
    end else if (sel_hit) begin
      bank_selector_r <= i_wdata;
    end
  end

  spir_reg8 #(
    .BANK (3'h1),
    .OFF  (OFF_0),
    .MASK (8'hff)
  ) u_lbl (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_legacy_baud_divisor[7:0])
  );

  spir_reg8 #(
    .BANK (3'h1),
    .OFF  (OFF_1),
    .MASK (8'hff)
  ) u_lbh (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_legacy_baud_divisor[15:8])
  );

  spir_reg8 #(
    .BANK (3'h2),
    .OFF  (OFF_0),
    .MASK (8'hff)
  ) u_bl (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_baud_divisor[7:0])
  );

  spir_reg8 #(
    .BANK (3'h2),
    .OFF  (OFF_1),
    .MASK (8'hff)
  ) u_bh (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_baud_divisor[15:8])
  );

  spir_reg8 #(
    .BANK (3'h2),
    .OFF  (OFF_2),
    .MASK (MSK_EXT1)
  ) u_x1 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_extended_control_1)
  );

  spir_reg8 #(
    .BANK (3'h2),
    .OFF  (OFF_4),
    .MASK (MSK_EXT2)
  ) u_x2 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_extended_control_2)
  );

  spir_reg8 #(
    .BANK (3'h2),
    .OFF  (OFF_6),
    .MASK (MSK_FLV)
  ) u_tfl (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_tx_fifo_level)
  );

  spir_reg8 #(
    .BANK (3'h2),
    .OFF  (OFF_7),
    .MASK (MSK_FLV)
  ) u_rfl (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_rx_fifo_level)
  );

  spir_reg8 #(
    .BANK (3'h4),
    .OFF  (OFF_2),
    .MASK (MSK_IRC1)
  ) u_ic1 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_ir_control_1)
  );

  spir_reg8 #(
    .BANK (3'h5),
    .OFF  (OFF_4),
    .MASK (MSK_IRC2)
  ) u_ic2 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_ir_control_2)
  );

  spir_reg8 #(
    .BANK (3'h6),
    .OFF  (OFF_0),
    .MASK (MSK_IRC3)
  ) u_ic3 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_ir_control_3)
  );

  spir_reg8 #(
    .BANK (3'h6),
    .OFF  (OFF_2),
    .MASK (MSK_SPW)
  ) u_spw (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_sir_pulse_width)
  );

  spir_reg8 #(
    .BANK (3'h7),
    .OFF  (OFF_4),
    .MASK (MSK_CFG1)
  ) u_cf1 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_ir_interface_config_1)
  );

  spir_reg8 #(
    .BANK (3'h7),
    .OFF  (OFF_6),
    .MASK (MSK_CFG3)
  ) u_cf3 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_ir_interface_config_3)
  );

  spir_reg8 #(
    .BANK (3'h7),
    .OFF  (OFF_7),
    .MASK (MSK_CFG4)
  ) u_cf4 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (bus),
    .o_q       (o_ir_interface_config_4)
  );

  // read mux; bank 0 reads zero except the selector
  always_comb begin
    rd_nxt = RST_VAL;
    if (i_addr == OFF_SEL) begin
      rd_nxt = bank_selector_r;
    end else begin
      unique case (bank)
        3'h1: begin
          case (i_addr)
            OFF_0:   rd_nxt = o_legacy_baud_divisor[7:0];
            OFF_1:   rd_nxt = o_legacy_baud_divisor[15:8];
            default: rd_nxt = RST_VAL;
          endcase
        end

        3'h2: begin
          case (i_addr)
            OFF_0:   rd_nxt = o_baud_divisor[7:0];
            OFF_1:   rd_nxt = o_baud_divisor[15:8];
            OFF_2:   rd_nxt = o_extended_control_1;
            OFF_4:   rd_nxt = o_extended_control_2;
            OFF_6:   rd_nxt = o_tx_fifo_level;
            OFF_7:   rd_nxt = o_rx_fifo_level;
            default: rd_nxt = RST_VAL;
          endcase
        end

        3'h3: begin
          case (i_addr)
            OFF_0:   rd_nxt = {MODULE_ID, REVISION_ID};
            OFF_1:   rd_nxt = bank_selector_r;
            OFF_2:   rd_nxt = i_fifo_control_shadow & ~8'h08;
            default: rd_nxt = RST_VAL;
          endcase
        end

        3'h4: begin
          case (i_addr)
            OFF_2:   rd_nxt = o_ir_control_1;
            default: rd_nxt = RST_VAL;
          endcase
        end

        3'h5: begin
          case (i_addr)
            OFF_4:   rd_nxt = o_ir_control_2;
            default: rd_nxt = RST_VAL;
          endcase
        end

        3'h6: begin
          case (i_addr)
            OFF_0:   rd_nxt = o_ir_control_3;
            OFF_2:   rd_nxt = o_sir_pulse_width;
            default: rd_nxt = RST_VAL;
          endcase
        end

        3'h7: begin
          case (i_addr)
            OFF_0:   rd_nxt = i_ir_rx_demod_control;
            OFF_1:   rd_nxt = i_ir_tx_mod_control;
            OFF_2:   rd_nxt = i_consumer_ir_config & MSK_CONSUMER_IR_CONFIG;
            OFF_4:   rd_nxt = o_ir_interface_config_1;
            OFF_6:   rd_nxt = o_ir_interface_config_3;
            OFF_7:   rd_nxt = o_ir_interface_config_4;
            default: rd_nxt = RST_VAL;
          endcase
        end
        default: rd_nxt = RST_VAL;
      endcase
    end
  end

  // zero outside the answer cycle keeps a stale byte off the host bus
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_r <= RST_VAL;
    end else if (i_rd) begin
      rdata_r <= rd_nxt;
    end else begin
      rdata_r <= RST_VAL;
    end
  end

  // dma channel use lives in the datapath; line control mirrors selector
  assign o_rdata        = rdata_r;
  assign o_line_control = bank_selector_r;
  assign o_active_bank  = bank;
  assign o_bank0_sel    = (bank == 3'h0);
  assign o_ir_only_bank = bank[2];
endmodule

// file: tb/spir_regs_chk.sv
// Purpose: port checker for the banked register file
// Assumes: one clock, sync reset
// Notes:   read data judged in the cycle after the strobe
`timescale 1ns/10ps
module spir_regs_chk
  import spir_pkg::*;
#(
  parameter logic [3:0] MODULE_ID   = 4'h1,
  parameter logic [3:0] REVISION_ID = 4'h1
) (
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_bank0_sel,
  input wire logic [7:0] i_ir_rx_demod_control,
  input wire logic [7:0] o_line_control,
  input wire logic [2:0] o_active_bank,
  input wire logic       o_ir_only_bank
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero without read");
  a_sel_write_any: assert property (i_wr && i_addr == OFF_SEL |=> o_line_control == $past(i_wdata))
    else $error("selector write lost");
  a_sel_read_back: assert property (i_rd && i_addr == OFF_SEL |=> o_rdata == $past(o_line_control))
    else $error("selector readback wrong");
  a_bank0_decode: assert property (!o_line_control[7] |-> o_active_bank == 3'h0 && o_bank0_sel)
    else $error("bank 0 decode wrong");
  a_bank1_decode: assert property (o_line_control[7] && (!o_line_control[6] || o_line_control[1:0] != 2'h0)
    |-> o_active_bank == 3'h1)
    else $error("bank 1 decode wrong");
  a_upper_decode: assert property (o_line_control[7:5] == 3'h7 && o_line_control[1:0] == 2'h0
    && o_line_control[4:2] < 3'h6 |-> o_active_bank == o_line_control[4:2] + 3'h2)
    else $error("bank 2-7 decode wrong");
  a_ir_only_flag: assert property (o_ir_only_bank == (o_active_bank >= 3'h4))
    else $error("ir only flag wrong");
  a_ident_read: assert property (i_rd && i_addr == OFF_0 && o_active_bank == 3'h3
    |=> o_rdata == {MODULE_ID, REVISION_ID})
    else $error("ident read wrong");
  a_demod_read: assert property (i_rd && i_addr == OFF_0 && o_active_bank == 3'h7
    |=> o_rdata == $past(i_ir_rx_demod_control))
    else $error("demod readback wrong");
  a_resv_read: assert property (i_rd && o_active_bank == 3'h1 && (i_addr == OFF_2 || i_addr >= OFF_4)
    |=> o_rdata == 8'h00)
    else $error("reserved read not zero");
  cover property (i_rd && o_active_bank == 3'h7);
  cover property (i_wr && i_addr == OFF_SEL);
  cover property (i_wr && o_ir_only_bank);
endmodule

bind spir_regs spir_regs_chk #(.MODULE_ID(MODULE_ID), .REVISION_ID(REVISION_ID)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_bank0_sel(o_bank0_sel), .i_ir_rx_demod_control(i_ir_rx_demod_control),
  .o_line_control(o_line_control), .o_active_bank(o_active_bank), .o_ir_only_bank(o_ir_only_bank));

// file: tb/tb_top.sv
// Purpose: self-checking bench for the banked register file
// Assumes: read data one cycle after strobe
// Notes:   shadow inputs held at fixed patterns
`timescale 1ns/10ps
module tb_top
  import spir_pkg::*;
;
  logic        i_clk_sys, i_rst, i_wr, i_rd, o_bank0_sel, o_ir_only_bank;
  logic [2:0]  i_addr, o_active_bank;
  logic [7:0]  i_wdata, o_rdata, o_line_control, i_fifo_control_shadow, i_ir_rx_demod_control;
  logic [7:0]  i_ir_tx_mod_control, i_consumer_ir_config, o_extended_control_1, o_extended_control_2;
  logic [7:0]  o_tx_fifo_level, o_rx_fifo_level, o_ir_control_1, o_ir_control_2, o_ir_control_3;
  logic [7:0]  o_sir_pulse_width, o_ir_interface_config_1, o_ir_interface_config_3, o_ir_interface_config_4;
  logic [15:0] o_legacy_baud_divisor, o_baud_divisor;
  int          err_total, checks;
  localparam logic [10:0] BK [9] = '{{8'h80, 3'h1}, {8'hbf, 3'h1}, {8'hc2, 3'h1}, {8'he0, 3'h2},
    {8'he4, 3'h3}, {8'he8, 3'h4}, {8'hec, 3'h5}, {8'hf0, 3'h6}, {8'hf4, 3'h7}};
  localparam logic [18:0] MT [17] = '{{8'he0, 3'h2, MSK_EXT1}, {8'he0, 3'h4, MSK_EXT2},
    {8'he0, 3'h6, MSK_FLV}, {8'he0, 3'h7, MSK_FLV}, {8'he8, 3'h2, MSK_IRC1}, {8'hec, 3'h4, MSK_IRC2},
    {8'hf0, 3'h0, MSK_IRC3}, {8'hf0, 3'h2, MSK_SPW}, {8'hf4, 3'h4, MSK_CFG1}, {8'hf4, 3'h6, MSK_CFG3},
    {8'hf4, 3'h7, MSK_CFG4}, {8'he0, 3'h5, 8'h00}, {8'he8, 3'h0, 8'h00}, {8'hec, 3'h0, 8'h00},
    {8'hf0, 3'h1, 8'h00}, {8'hf4, 3'h5, 8'h00}, {8'he4, 3'h4, 8'h00}};
  spir_regs #(.MODULE_ID(4'h9), .REVISION_ID(4'h6)) dut (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_bank0_sel, .i_fifo_control_shadow, .i_ir_rx_demod_control, .i_ir_tx_mod_control,
    .i_consumer_ir_config, .o_line_control, .o_legacy_baud_divisor, .o_baud_divisor, .o_extended_control_1,
    .o_extended_control_2, .o_tx_fifo_level, .o_rx_fifo_level, .o_ir_control_1, .o_ir_control_2,
    .o_ir_control_3, .o_sir_pulse_width, .o_ir_interface_config_1, .o_ir_interface_config_3,
    .o_ir_interface_config_4, .o_active_bank, .o_ir_only_bank);
  always #10 i_clk_sys = ~i_clk_sys;
  task automatic give_verdict();
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk("o_rdata", {8'h00, o_rdata}, {8'h00, exp});
  endtask
  task automatic t_reset();
    chk("o_bank0_sel", o_bank0_sel, 1'b1);
    rd(OFF_SEL, 8'h00);
    rd(OFF_0, 8'h00);
  endtask
  task automatic t_decode();
    for (int i = 0; i < 9; i++) begin
      wr(OFF_SEL, BK[i][10:3]);
      chk("o_active_bank", o_active_bank, BK[i][2:0]);
      chk("o_ir_only_bank", o_ir_only_bank, BK[i][2:0] >= 3'h4);
      chk("o_line_control", o_line_control, BK[i][10:3]);
      rd(OFF_SEL, BK[i][10:3]);
    end
  endtask
  task automatic t_div();
    wr(OFF_SEL, 8'h80);
    wr(OFF_0, 8'ha5);
    wr(OFF_1, 8'h5a);
    chk("o_legacy_baud_divisor", o_legacy_baud_divisor, 16'h5aa5);
    wr(OFF_2, 8'hff);
    rd(OFF_2, 8'h00);
    wr(OFF_SEL, 8'he0);
    wr(OFF_0, 8'h3c);
    wr(OFF_1, 8'hc3);
    chk("o_baud_divisor", o_baud_divisor, 16'hc33c);
    chk("o_legacy_baud_divisor", o_legacy_baud_divisor, 16'h5aa5);
    rd(OFF_1, 8'hc3);
  endtask
  task automatic t_mask();
    for (int i = 0; i < 17; i++) begin
      wr(OFF_SEL, MT[i][18:11]);
      wr(MT[i][10:8], 8'hff);
      rd(MT[i][10:8], MT[i][7:0]);
    end
    chk("o_sir_pulse_width", o_sir_pulse_width, MSK_SPW);
    chk("o_ir_interface_config_4", o_ir_interface_config_4, MSK_CFG4);
    chk("o_extended_control_1", o_extended_control_1, MSK_EXT1);
    chk("o_extended_control_2", o_extended_control_2, MSK_EXT2);
    chk("o_tx_fifo_level", o_tx_fifo_level, MSK_FLV);
    chk("o_rx_fifo_level", o_rx_fifo_level, MSK_FLV);
    chk("o_ir_control_1", o_ir_control_1, MSK_IRC1);
    chk("o_ir_control_2", o_ir_control_2, MSK_IRC2);
    chk("o_ir_control_3", o_ir_control_3, MSK_IRC3);
    chk("o_ir_interface_config_1", o_ir_interface_config_1, MSK_CFG1);
    chk("o_ir_interface_config_3", o_ir_interface_config_3, MSK_CFG3);
  endtask
  task automatic t_ro();
    wr(OFF_SEL, 8'he4);
    rd(OFF_0, 8'h96);
    rd(OFF_1, 8'he4);
    rd(OFF_2, 8'hf7);
    wr(OFF_SEL, 8'hf4);
    wr(OFF_0, 8'hff);
    rd(OFF_0, 8'h5c);
    wr(OFF_1, 8'h00);
    rd(OFF_1, 8'ha3);
    rd(OFF_2, 8'hff & MSK_CONSUMER_IR_CONFIG);
  endtask
  // mid-run reset must drop the selector, baud divisor, ir interface config 4 and the bank back to 0
  task automatic t_rerst();
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    chk("o_line_control", o_line_control, 8'h00);
    chk("o_bank0_sel", o_bank0_sel, 1'b1);
    chk("o_baud_divisor", o_baud_divisor, 16'h0000);
    chk("o_ir_interface_config_4", o_ir_interface_config_4, 8'h00);
    rd(OFF_SEL, 8'h00);
  endtask
  initial begin
    i_clk_sys = 1'b0;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_fifo_control_shadow = 8'hff;
    i_ir_rx_demod_control = 8'h5c;
    i_ir_tx_mod_control = 8'ha3;
    i_consumer_ir_config = 8'hff;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_reset();
    t_decode();
    t_div();
    t_mask();
    t_ro();
    t_rerst();
    give_verdict();
  end
  // bounds the whole run against a hang
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
endmodule
